//--- enm_eae_core.sv
// Normalize and multiply datapath with APB register access
`timescale 1ns/1ns

module enm_eae_core #(
    parameter int HOLDOFF_CYCLES = enm_pkg::HOLDOFF_CYCLES_DEF
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire enm_pkg::enm_apb_req_t apb_req,
    output enm_pkg::enm_apb_rsp_t      apb_rsp,
    output logic                       opnd_req,
    input  wire logic                  opnd_ack,
    input  wire logic [17:0]           opnd_data,
    output logic                       intr_holdoff,
    output logic                       busy
);
    import enm_pkg::*;

    //------------------------------------------------------------------
    // Elaboration checks
    //------------------------------------------------------------------
    if (HOLDOFF_CYCLES < 1 || HOLDOFF_CYCLES > 15) begin : g_chk
        $error("HOLDOFF_CYCLES must lie in 1..15");
    end

    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    enm_state_t         state;         // Event-time state
    logic [0:WORD_W-1]  instr;         // Instruction being run
    logic [0:WORD_W-1]  main_arith_reg; // Main register, bit 0 is sign
    logic [0:WORD_W-1]  extension_reg; // Extension register
    logic [0:WORD_W-1]  operand_in_reg; // Multiplicand
    logic               link;          // Sign carry bit
    logic [CNT_W-1:0]   step_counter;  // Up-counting step counter
    logic               sign_differ;   // Product sign negative
    logic [3:0]         hold_cnt;      // Hold-off cycles left
    logic [CNT_W-1:0]   cnt_inc;       // Counter plus one
    logic [2:0]         op;            // Decoded op code
    logic               signed_op;     // Signed form of op
    logic [CNT_W-1:0]   step_neg;      // Negated step field
    logic               normalized;    // Bits 0 and 1 differ
    logic [WORD_W:0]    sum;           // Adder with carry
    logic               wr_acc;        // APB write access
    logic               rd_setup;      // APB setup of any access
    logic               mapped;        // Address decodes
    logic               loop_done;     // Shift loop ends
    logic [31:0]        rdata;         // Read data register
    logic               slverr;        // Error answer register

    //------------------------------------------------------------------
    // Decode and helpers
    //------------------------------------------------------------------
    assign op        = instr[F_OP_HI +: 3];
    assign signed_op = (op == OP_LEFTJUSTIFY_OP) ? instr[F_SGN_LEFTJUSTIFY_OP]
                                       : instr[F_SGN_MUL];
    assign step_neg  = CNT_W'(~instr[F_STEP_LO +: CNT_W] + 1'b1);
    assign cnt_inc   = CNT_W'(step_counter + 1'b1);
    assign normalized = main_arith_reg[0] != main_arith_reg[1];
    assign sum = {1'b0, main_arith_reg}
               + {1'b0, (extension_reg[WORD_W-1] ? operand_in_reg
                                                 : RST_WORD)};
    assign loop_done = (cnt_inc == RST_CNT);

    // Bus decode; pready is always high so every access phase is one wait-free cycle
    assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_setup = apb_req.psel & ~apb_req.penable;
    always_comb begin
        case (apb_req.paddr)
            OFS_CMD, OFS_STATUS, OFS_MAIN, OFS_EXT,
            OFS_LINK, OFS_STEP, OFS_OPND: mapped = 1'b1;
            default:                      mapped = 1'b0;
        endcase
    end

    //------------------------------------------------------------------
    // Event-time sequencer
    //------------------------------------------------------------------
    // A, B, C, D then E loop and F
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    // Command write starts a new instruction
                    if (wr_acc && mapped && apb_req.paddr == OFS_CMD) begin
                        state <= S_EV_A;
                    end
                end
                S_EV_A:  state <= S_EV_B;
                S_EV_B:  state <= S_EV_C;
                S_EV_C:  state <= S_EV_D;
                S_EV_D: begin
                    // Setup ops use only four event times
                    if (op == OP_MUL) begin
                        state <= S_FETCH;
                    end else if (op == OP_LEFTJUSTIFY_OP) begin
                        state <= S_EV_E;
                    end else begin
                        state <= S_IDLE;
                    end
                end
                S_FETCH: begin
                    if (opnd_ack) begin
                        state <= (step_counter == RST_CNT) ? S_EV_F : S_EV_E;
                    end
                end
                S_EV_E: begin
                    if (op == OP_LEFTJUSTIFY_OP && normalized) begin
                        state <= S_EV_F;
                    end else if (loop_done) begin
                        state <= S_EV_F;
                    end
                end
                S_EV_F:  state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------------
    // Instruction register
    //------------------------------------------------------------------
    // Only taken while idle so a running op never sees its code change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr <= RST_WORD;
        end else if (state == S_IDLE && wr_acc && apb_req.paddr == OFS_CMD) begin
            instr <= pwdata_w();
        end
    end

    // Low data bits of the write bus
    function automatic logic [WORD_W-1:0] pwdata_w();
        pwdata_w = apb_req.pwdata[WORD_W-1:0];
    endfunction

    //------------------------------------------------------------------
    // Step counter
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_counter <= RST_CNT;
        end else begin
            case (state)
                S_IDLE: begin
                    // Software may preload the counter while idle
                    if (wr_acc && apb_req.paddr == OFS_STEP) begin
                        step_counter <= apb_req.pwdata[CNT_W-1:0];
                    end
                end
                S_EV_A: begin
                    if (op != OP_SETUP) begin
                        step_counter <= step_neg;
                    end
                end
                S_EV_E: begin
                    if (!(op == OP_LEFTJUSTIFY_OP && normalized)) begin
                        step_counter <= cnt_inc;
                    end
                end
                default: step_counter <= step_counter;
            endcase
        end
    end

    //------------------------------------------------------------------
    // Sign-differ flag
    //------------------------------------------------------------------
    // set when link and sign differ
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sign_differ <= 1'b0;
        end else if (state == S_EV_A) begin
            sign_differ <= (op == OP_MUL) && signed_op
                         && (link != main_arith_reg[0]);
        end
    end

    //------------------------------------------------------------------
    // Multiplicand fetch
    //------------------------------------------------------------------
    // next word taken into operand register
    assign opnd_req = (state == S_FETCH);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand_in_reg <= RST_WORD;
        end else if (opnd_req && opnd_ack) begin
            operand_in_reg <= opnd_data;
        end
    end

    //------------------------------------------------------------------
    // Main, extension and link datapath
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_arith_reg <= RST_WORD;
            extension_reg  <= RST_WORD;
            link           <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    // Software loads operands only between instructions
                    if (wr_acc && apb_req.paddr == OFS_MAIN) begin
                        main_arith_reg <= pwdata_w();
                    end
                    if (wr_acc && apb_req.paddr == OFS_EXT) begin
                        extension_reg <= pwdata_w();
                    end
                    if (wr_acc && apb_req.paddr == OFS_LINK) begin
                        link <= apb_req.pwdata[0];
                    end
                end
                S_EV_A: begin
                    if (op == OP_LEFTJUSTIFY_OP && signed_op) begin
                        link <= main_arith_reg[0];
                    end
                    if (op == OP_MUL && signed_op) begin
                        link <= 1'b0;
                    end
                end
                S_EV_B: begin
                    if (op == OP_MUL) begin
                        if (signed_op && main_arith_reg[0]) begin
                            extension_reg <= ~main_arith_reg;
                        end else begin
                            extension_reg <= main_arith_reg;
                        end
                    end
                end
                S_EV_C: begin
                    if (op == OP_MUL) begin
                        main_arith_reg <= RST_WORD;
                    end else if (op == OP_SETUP) begin
                        // count ORed or loaded into main
                        main_arith_reg <=
                            (instr[F_SETUP_CLR] ? RST_WORD : main_arith_reg)
                          | (instr[F_SETUP_OR] ? {12'h000, step_counter}
                                               : RST_WORD);
                    end
                end
                S_EV_E: begin
                    if (op == OP_LEFTJUSTIFY_OP) begin
                        if (!normalized) begin
                            main_arith_reg <= {main_arith_reg[1:WORD_W-1],
                                               extension_reg[0]};
                            extension_reg  <= {extension_reg[1:WORD_W-1],
                                               link};
                        end
                    end else begin
                        // add and shift right builds product
                        main_arith_reg <= sum[WORD_W:1];
                        extension_reg  <= {sum[0],
                                           extension_reg[0:WORD_W-2]};
                    end
                end
                S_EV_F: begin
                    // main also inverted so bits 0,1 carry sign
                    if (op == OP_MUL && sign_differ) begin
                        extension_reg  <= ~extension_reg;
                        main_arith_reg <= ~main_arith_reg;
                    end
                end
                default: link <= link;
            endcase
        end
    end

    //------------------------------------------------------------------
    // Interrupt hold-off
    //------------------------------------------------------------------
    // hold-off after normalize ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 4'h0;
        end else if (state == S_EV_F && op == OP_LEFTJUSTIFY_OP) begin
            hold_cnt <= 4'(HOLDOFF_CYCLES);
        end else if (hold_cnt != 4'h0) begin
            hold_cnt <= 4'(hold_cnt - 1'b1);
        end
    end
    assign intr_holdoff = (hold_cnt != 4'h0);
    assign busy         = (state != S_IDLE);

    //------------------------------------------------------------------
    // APB read data and error answer
    //------------------------------------------------------------------
    // Captured in the setup cycle so data comes from flip-flops yet
    // the access phase still completes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata  <= 32'h00000000;
            slverr <= 1'b0;
        end else if (rd_setup) begin
            slverr <= ~mapped;
            case (apb_req.paddr)
                OFS_CMD:    rdata <= {14'h0000, instr};
                OFS_STATUS: rdata <= {28'h0000000, link,
                                      intr_holdoff, sign_differ, busy};
                OFS_MAIN:   rdata <= {14'h0000, main_arith_reg};
                OFS_EXT:    rdata <= {14'h0000, extension_reg};
                OFS_LINK:   rdata <= {31'h00000000, link};
                OFS_STEP:   rdata <= {26'h0000000, step_counter};
                OFS_OPND:   rdata <= {14'h0000, operand_in_reg};
                default:    rdata <= 32'h00000000;
            endcase
        end
    end

    assign apb_rsp.prdata  = rdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = slverr & apb_req.psel & apb_req.penable;

endmodule // enm_eae_core

//--- enm_eae_core_props.sv
// Port checker for the normalize/multiply datapath
`timescale 1ns/1ns
module enm_eae_core_props #(
    parameter int HOLDOFF_CYCLES = enm_pkg::HOLDOFF_CYCLES_DEF
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire enm_pkg::enm_apb_req_t apb_req,
    input wire enm_pkg::enm_apb_rsp_t apb_rsp,
    input wire logic                  opnd_req,
    input wire logic                  opnd_ack,
    input wire logic [17:0]           opnd_data,
    input wire logic                  intr_holdoff,
    input wire logic                  busy
);
    import enm_pkg::*;
    // ----
    // Helper state
    // ----
    logic [2:0] op_q;   // Opcode of the running instruction
    logic [5:0] fld_q;  // Its step field
    logic [6:0] step_n; // Busy cycles since the operand was taken
    logic [3:0] hold_n; // Hold-off cycles so far
    // Accepted start: writes while busy are refused, so they must not count
    wire cmd_go = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == OFS_CMD && !busy;
    // Latch opcode and field; reset to an unused code so nothing fires early
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q  <= 3'h7;
            fld_q <= 6'h00;
        end else if (cmd_go) begin
            op_q  <= apb_req.pwdata[8:6];
            fld_q <= apb_req.pwdata[5:0];
        end
    end
    // Length of the arithmetic phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) step_n <= 7'h00;
        else if (opnd_req && opnd_ack) step_n <= 7'h00;
        else if (busy) step_n <= step_n + 7'h01;
    end
    // Length of the hold-off pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hold_n <= 4'h0;
        else if (intr_holdoff) hold_n <= hold_n + 4'h1;
        else hold_n <= 4'h0;
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_opnd_hold; opnd_req && !opnd_ack |=> opnd_req; endproperty
    a_opnd_hold: assert property (p_opnd_hold) else $error("operand request dropped");
    property p_opnd_drop; opnd_req && opnd_ack |=> !opnd_req && busy; endproperty
    a_opnd_drop: assert property (p_opnd_drop) else $error("operand request not ended");
    property p_start; cmd_go |=> busy; endproperty
    a_start: assert property (p_start) else $error("instruction not started");
    property p_setup_len; cmd_go && apb_req.pwdata[8:6] == OP_SETUP |=> busy [*4] ##1 !busy; endproperty
    a_setup_len: assert property (p_setup_len) else $error("setup length wrong");
    property p_mul_prep; cmd_go && apb_req.pwdata[8:6] == OP_MUL |=> (busy && !opnd_req) [*4] ##1 opnd_req;
    endproperty
    a_mul_prep: assert property (p_mul_prep) else $error("multiply prep length wrong");
    property p_mul_steps; $fell(busy) && op_q == OP_MUL |-> step_n == {1'b0, fld_q} + 7'h01; endproperty
    a_mul_steps: assert property (p_mul_steps) else $error("multiply step count wrong");
    property p_hold_len; $fell(intr_holdoff) |-> hold_n == HOLDOFF_CYCLES; endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold-off length wrong");
    property p_hold_after; $fell(busy) && op_q == OP_LEFTJUSTIFY_OP |-> ##[0:1] intr_holdoff; endproperty
    a_hold_after: assert property (p_hold_after) else $error("no hold-off after normalize");
    property p_leftjustify_op_wrap; cmd_go && apb_req.pwdata[8:0] == 9'h101 |=> busy [*6] ##[1:2] !busy; endproperty
    a_leftjustify_op_wrap: assert property (p_leftjustify_op_wrap) else $error("counter wrap did not stop");
endmodule // enm_eae_core_props

bind enm_eae_core enm_eae_core_props #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) i_enm_eae_core_props (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .opnd_req(opnd_req),
    .opnd_ack(opnd_ack), .opnd_data(opnd_data), .intr_holdoff(intr_holdoff), .busy(busy));

//--- enm_eae_core_tb_top.sv
// Self-checking bench for the normalize/multiply datapath
`timescale 1ns/1ns
module enm_eae_core_tb_top;
    import enm_pkg::*;
    // ----
    // Signals
    // ----
    logic         pclk, presetn;                    // Clock and reset
    enm_apb_req_t apb_req;                          // Bus request
    enm_apb_rsp_t apb_rsp;                          // Bus answer
    logic         opnd_req, opnd_ack, intr_holdoff, busy;
    logic [17:0]  opnd_data, cand;                  // Operand and its source value
    logic [3:0]   dly;                              // Partner stall
    logic [31:0]  rv;                               // Last read data
    logic         slv;                              // Last error answer
    int           n_mismatch = 0, n_checks = 0, cyc = 0;

    enm_eae_core #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES_DEF)) i_enm_eae_core (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .opnd_req(opnd_req),
        .opnd_ack(opnd_ack), .opnd_data(opnd_data), .intr_holdoff(intr_holdoff), .busy(busy));
    enm_opnd_model i_enm_opnd_model (.pclk(pclk), .presetn(presetn), .opnd_req(opnd_req), .cand(cand),
        .dly(dly), .opnd_ack(opnd_ack), .opnd_data(opnd_data));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // ----
    // Shared tasks
    // ----
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // One transfer; request held until pready is seen high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rv = apb_rsp.prdata;
        slv = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [35:0] e);
        apb(a, 1'b0, 32'h00000000);
        chk(nm, e, {4'h0, rv});
    endtask
    // Start an instruction, optionally poke it while busy, wait for the end
    task automatic go(input logic [17:0] i, input bit poke);
        apb(OFS_CMD, 1'b1, {14'h0, i});
        if (poke) begin
            apb(OFS_CMD, 1'b1, 32'h00034101);
            apb(OFS_MAIN, 1'b1, 32'h00000001);
        end
        @(negedge pclk);
        while (busy !== 1'b0) @(negedge pclk);
    endtask
    task automatic run_op(input logic [17:0] m, x, input logic l, input logic [17:0] i, input bit poke);
        apb(OFS_MAIN, 1'b1, {14'h0, m});
        apb(OFS_EXT, 1'b1, {14'h0, x});
        apb(OFS_LINK, 1'b1, {31'h0, l});
        go(i, poke);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        chk("busy", 36'h0, {35'h0, busy});
        chk("holdoff", 36'h0, {35'h0, intr_holdoff});
        chk("opnd_req", 36'h0, {35'h0, opnd_req});
        rchk("step", OFS_STEP, {30'h0, RST_CNT});
        rchk("main", OFS_MAIN, {18'h0, RST_WORD});
        rchk("unmapped", 8'h40, 36'h0);
        chk("slverr", 36'h1, {35'h0, slv});
        apb(OFS_OPND, 1'b1, 32'h00000155);
        rchk("opnd ro", OFS_OPND, 36'h0);
    endtask
    task automatic t_leftjustify_op_u();
        run_op(18'h00000, 18'h00003, 1'b0, 18'h34124, 0);
        chk("holdoff", 36'h1, {35'h0, intr_holdoff});
        rchk("main", OFS_MAIN, 36'h18000);
        rchk("ext", OFS_EXT, 36'h0);
        rchk("step", OFS_STEP, 36'h3d);
        go(18'h34001, 0);
        rchk("or count", OFS_MAIN, 36'h1803d);
        go(18'h34201, 0);
        rchk("load count", OFS_MAIN, 36'h0003d);
    endtask
    task automatic t_leftjustify_op_s();
        run_op(18'h3ffff, 18'h20000, 1'b0, 18'h36124, 0);
        rchk("main", OFS_MAIN, 36'h20000);
        rchk("ext", OFS_EXT, 36'h3ffff);
        rchk("link", OFS_LINK, 36'h1);
        rchk("step", OFS_STEP, 36'h2e);
    endtask
    task automatic t_restore();
        run_op(18'h08000, 18'h00000, 1'b0, 18'h34105, 0);
        rchk("main", OFS_MAIN, 36'h10000);
        rchk("step", OFS_STEP, 36'h3c);
        run_op(18'h00000, 18'h00000, 1'b0, 18'h34101, 0);
        rchk("step wrap", OFS_STEP, 36'h0);
    endtask
    task automatic t_mul();
        logic [17:0] hi;
        cand <= 18'h3ffff;
        run_op(18'h3ffff, 18'h00000, 1'b0, 18'h35652, 0);
        chk("no holdoff", 36'h0, {35'h0, intr_holdoff});
        rchk("prod hi", OFS_MAIN, 36'h3fffe);
        rchk("prod lo", OFS_EXT, 36'h00001);
        rchk("operand", OFS_OPND, 36'h3ffff);
        cand <= 18'h00007;
        run_op(18'h0000b, 18'h00000, 1'b0, 18'h35644, 0);
        apb(OFS_MAIN, 1'b0, 32'h00000000);
        hi = rv[17:0];
        apb(OFS_EXT, 1'b0, 32'h00000000);
        chk("scaled", 36'h4d, {hi, rv[17:0]} >> 14);
    endtask
    // Like signs, then unlike with each operand negative; slow operand
    task automatic t_product_signed_op();
        logic [17:0] m;
        logic        l;
        for (int k = 0; k < 3; k++) begin
            m = (k == 1) ? 18'h00005 : 18'h3fffa;
            l = (k != 2);
            cand <= 18'h00002;
            dly <= 4'h5;
            run_op(m, 18'h00000, l, 18'h35e52, k == 1);
            rchk("prod hi", OFS_MAIN, (k == 0) ? 36'h00000 : 36'h3ffff);
            rchk("prod lo", OFS_EXT, (k == 0) ? 36'h0000a : 36'h3fff5);
            apb(OFS_STATUS, 1'b0, 32'h00000000);
            chk("link differ", {35'h0, k != 0}, {34'h0, rv[3], rv[1]});
        end
    endtask

    initial begin
        apb_req = '0;
        presetn = 1'b0;
        cand = 18'h00000;
        dly = 4'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_leftjustify_op_u();
        t_leftjustify_op_s();
        t_restore();
        t_mul();
        t_product_signed_op();
        report_and_stop();
    end
endmodule // enm_eae_core_tb_top

//--- enm_opnd_model.sv
// Processor-side model that supplies the multiplicand word
`timescale 1ns/1ns
module enm_opnd_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        opnd_req,  // Device waits for the word
    input  wire logic [17:0] cand,      // Word at the next location
    input  wire logic [3:0]  dly,       // Stall cycles before answering
    output logic             opnd_ack,  // One-cycle answer strobe
    output logic [17:0]      opnd_data  // Valid only with the strobe
);
    logic [3:0] wait_n; // Stall cycles so far
    // ----
    // Answer
    // ----
    // one word per request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd_ack  <= 1'b0;
            opnd_data <= 18'h00000;
            wait_n    <= 4'h0;
        end else if (opnd_ack) begin
            // Lines turn to the inverse so a late sample cannot pass
            opnd_ack  <= 1'b0;
            opnd_data <= ~opnd_data;
            wait_n    <= 4'h0;
        end else if (opnd_req && wait_n == dly) begin
            opnd_ack  <= 1'b1;
            opnd_data <= cand;
        end else if (opnd_req) begin
            wait_n <= wait_n + 4'h1;
        end
    end
endmodule // enm_opnd_model

//--- enm_pkg.sv
// Constants, types and register map of the normalize/multiply datapath
//------------------------------------------------------------------
// Function
// - normalize shifts left until bits 0,1 differ or the step counter counts up to zero
// - signed normalize copies sign into link first
// - shift moves ext0->main17, link->ext17, drops main0
// - step counter advances once per normalize shift
// - step counter readable via or/load count ops
// - normalize loads counter with negated step field
// - interrupts held off two cycles after normalize
// - restore-form normalize loads counter, shift adds one
// - multiply forms 36-bit product from 18-bit operands
// - reduced count gives product scaled 18-n places
// - multiply prep moves main to ext, clears main
// - multiply fetches multiplicand into operand register
// - multiply ends when counter counts up to zero
// - each step adds multiplicand if lsb set, shifts right
// - signed prep sets differ flag, clears link
// - signed prep complements negative multiplier
// - signed product has sign in main bits 0,1
// - differ flag complements ext after arithmetic
// - instructions sequence through event times A to D, normalize and multiply on through F
//------------------------------------------------------------------
package enm_pkg;

    // Datapath widths
    localparam int WORD_W = 18;
    localparam int CNT_W  = 6;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MAIN   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_EXT    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_LINK   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STEP   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_OPND   = 8'h18;

    // Instruction field positions, bit 0 is the most significant
    localparam int F_SGN_LEFTJUSTIFY_OP  = 4;
    localparam int F_SGN_MUL   = 6;
    localparam int F_SETUP_CLR = 8;
    localparam int F_OP_HI     = 9;
    localparam int F_STEP_LO   = 12;
    localparam int F_SETUP_OR  = 17;

    // Operation codes in instruction bits 9..11
    localparam logic [2:0] OP_SETUP = 3'h0;
    localparam logic [2:0] OP_MUL   = 3'h1;
    localparam logic [2:0] OP_LEFTJUSTIFY_OP  = 3'h4;

    // Status register bit positions
    localparam int ST_BUSY   = 0;
    localparam int ST_DIFFER = 1;
    localparam int ST_HOLD   = 2;
    localparam int ST_LINK   = 3;

    // Reset values
    localparam logic [WORD_W-1:0] RST_WORD = 18'h00000;
    localparam logic [CNT_W-1:0]  RST_CNT  = 6'h00;

    // Interrupt hold-off length in clock cycles
    localparam int HOLDOFF_CYCLES_DEF = 2;

    // Event-time sequencer states
    typedef enum logic [2:0] {
        S_IDLE, S_EV_A, S_EV_B, S_EV_C, S_EV_D, S_FETCH, S_EV_E, S_EV_F
    } enm_state_t;

    // APB request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } enm_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } enm_apb_rsp_t;

endpackage : enm_pkg
